/* verilog/tbh_host.sv */
// Host controller driving a TAP master over its 8-bit ready-handshake bus
// How it works
// RULE_01 - TAP advances on TMS at TCK rise
// RULE_02 - Sixteen states, six stable, ten transient
// RULE_03 - Power-up, reset pin, soft bit reach reset
// RULE_04 - Target in reset loads identify or bypass
// RULE_05 - Capture-DR loads data on leaving edge
// RULE_06 - Shift-DR enables TDO at first fall
// RULE_07 - Exit-DR may reshift; TDO floats after Exit1
// RULE_08 - Data update on fall in Update-DR
// RULE_09 - Capture-IR loads status on leaving edge
// RULE_10 - Shift-IR enables TDO at first fall
// RULE_11 - Exit-IR may reshift; TDO floats after Exit1
// RULE_12 - New instruction current on Update-IR fall
// RULE_13 - Bytes LSB first, partial byte right-justified
// RULE_14 - Command written before any outgoing bytes
// RULE_15 - Full flag bit 6; aborted write dropped
// RULE_16 - Input-only drives TDO high; recirculate echoes
// RULE_17 - Discrete mode bypasses buffers, blocks commands
// RULE_18 - Loopback feeds input buffer, pins held high
// RULE_19 - Empty flag bit 7; bytes LSB first
// RULE_20 - TDI sampling delayed by retime field
// RULE_21 - Output-only scans ignore TDI entirely
// RULE_22 - Any reset restores defaults, clears buffers
`default_nettype none
`include "tbh_regs.svh"
module tbh_host (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic [4:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic      [2:0]  dev_addr_o,
  output logic      [7:0]  dev_d_o,
  output logic             dev_d_oe_o,
  input  wire logic [7:0]  dev_d_i,
  output logic             dev_read_o,
  output logic             dev_strobe_n_o,
  input  wire logic        dev_rdy_i,
  output logic             dev_rst_n_o,
  output logic             busy_o
);
  // ========================================================================
  // Helpers
  // Next TAP state from current state and TMS
  function automatic tbh_pkg::tbh_tap_e tap_next(tbh_pkg::tbh_tap_e s, logic tms);
    case (s)
      tbh_pkg::TAP_TLR:  return tms ? tbh_pkg::TAP_TLR  : tbh_pkg::TAP_RTI;
      tbh_pkg::TAP_RTI:  return tms ? tbh_pkg::TAP_SDRS : tbh_pkg::TAP_RTI;
      tbh_pkg::TAP_SDRS: return tms ? tbh_pkg::TAP_SIRS : tbh_pkg::TAP_CDR;
      tbh_pkg::TAP_CDR:  return tms ? tbh_pkg::TAP_E1DR : tbh_pkg::TAP_SDR;
      tbh_pkg::TAP_SDR:  return tms ? tbh_pkg::TAP_E1DR : tbh_pkg::TAP_SDR;
      tbh_pkg::TAP_E1DR: return tms ? tbh_pkg::TAP_UDR  : tbh_pkg::TAP_PDR;
      tbh_pkg::TAP_PDR:  return tms ? tbh_pkg::TAP_E2DR : tbh_pkg::TAP_PDR;
      tbh_pkg::TAP_E2DR: return tms ? tbh_pkg::TAP_UDR  : tbh_pkg::TAP_SDR;
      tbh_pkg::TAP_UDR:  return tms ? tbh_pkg::TAP_SDRS : tbh_pkg::TAP_RTI;
      tbh_pkg::TAP_SIRS: return tms ? tbh_pkg::TAP_TLR  : tbh_pkg::TAP_CIR;
      tbh_pkg::TAP_CIR:  return tms ? tbh_pkg::TAP_E1IR : tbh_pkg::TAP_SIR;
      tbh_pkg::TAP_SIR:  return tms ? tbh_pkg::TAP_E1IR : tbh_pkg::TAP_SIR;
      tbh_pkg::TAP_E1IR: return tms ? tbh_pkg::TAP_UIR  : tbh_pkg::TAP_PIR;
      tbh_pkg::TAP_PIR:  return tms ? tbh_pkg::TAP_E2IR : tbh_pkg::TAP_PIR;
      tbh_pkg::TAP_E2IR: return tms ? tbh_pkg::TAP_UIR  : tbh_pkg::TAP_SIR;
      tbh_pkg::TAP_UIR:  return tms ? tbh_pkg::TAP_SDRS : tbh_pkg::TAP_RTI;
      default:           return tbh_pkg::TAP_TLR;
    endcase
  endfunction : tap_next

  // Whole bytes needed for a bit count
  function automatic logic [2:0] nbytes(logic [5:0] bits);
    logic [5:0] s;
    s = bits + 6'h07;
    return s[5:3];
  endfunction : nbytes

  // Discrete-control byte with reset pin kept inactive
  function automatic logic [7:0] disc_byte(logic tck, logic tms, logic tdo);
    logic [7:0] b;
    b = 8'h00;
    b[`TBH_DC_TCK]  = tck;
    b[`TBH_DC_TMS]  = tms;
    b[`TBH_DC_TDO]  = tdo;
    b[`TBH_DC_TRST] = 1'b1;
    return b;
  endfunction : disc_byte

  // ========================================================================
  // Reset release and pin synchronisers
  logic       rst_n;
  logic [8:0] pins_s;
  logic [7:0] d_s;
  logic       rdy_s;

  tbh_sync #(.W(1)) u_rst (
    .clock_i (clock_i), .rstn_i (rstn_i), .ce_i (1'b1), .d_i (1'b1), .q_o (rst_n)
  );
  tbh_sync #(.W(9)) u_pins (
    .clock_i (clock_i), .rstn_i (rst_n), .ce_i (ce_i),
    .d_i ({dev_rdy_i, dev_d_i}), .q_o (pins_s)
  );
  assign d_s   = pins_s[7:0];
  assign rdy_s = pins_s[8];

  // ========================================================================
  // State
  tbh_pkg::tbh_seq_e seq_q;
  tbh_pkg::tbh_bus_e bus_q;
  tbh_pkg::tbh_tap_e tap_q;
  tbh_pkg::tbh_op_e  op_q;
  logic        dev_rst_q, tms_q, tdo_q, err_q, abort_q, tdi_q, live_q, cap_q, upd_q;
  logic        cmd_sent_q;
  logic [7:0]  cmd_q, dstat_q, rbyte_q;
  logic [5:0]  txbits_q, rxbits_q;
  logic [31:0] tx_q, rx_q, rdata_q;
  logic [2:0]  idx_q;
  logic [8:0]  cnt_q;

  // ========================================================================
  // Local register decode
  wire               w_ctrl = wr_i && (addr_i == `TBH_A_CTRL);
  wire               go     = w_ctrl && wdata_i[`TBH_CTRL_GO] && (seq_q == tbh_pkg::S_IDLE);
  wire               w_stat = wr_i && (addr_i == `TBH_A_STAT);
  wire tbh_pkg::tbh_op_e new_op = tbh_pkg::tbh_op_e'(wdata_i[`TBH_CTRL_OP +: `TBH_CTRL_OP_W]);
  wire tbh_pkg::tbh_seq_e first =
      (new_op == tbh_pkg::OP_SCAN) ? tbh_pkg::S_CMD  :
      (new_op == tbh_pkg::OP_DISC) ? tbh_pkg::S_DLO  :
      (new_op == tbh_pkg::OP_SRST) ? tbh_pkg::S_SRST : tbh_pkg::S_POLL;

  // Byte bookkeeping for the scan data words
  wire [2:0]  tx_n   = nbytes(txbits_q);
  wire [2:0]  rx_n   = nbytes(rxbits_q);
  wire [2:0]  idx_up = idx_q + 3'h1;
  wire [5:0]  tx_rem = txbits_q - {idx_q, 3'h0};
  wire [7:0]  tx_msk = (tx_rem >= 6'h08) ? 8'hff : ~(8'hff << tx_rem[2:0]);
  wire [7:0]  tx_byte = tx_q[{idx_q[1:0], 3'h0} +: 8] & tx_msk;  // [RULE_13]
  wire tbh_pkg::tbh_seq_e after_tx = (rx_n != 3'h0) ? tbh_pkg::S_RX : tbh_pkg::S_IDLE;

  // Status word and read selection
  wire [31:0] stat_w = {11'h000, upd_q, cap_q, (tap_q == tbh_pkg::TAP_TLR), live_q,
                        4'(tap_q), tdi_q, dstat_q[`TBH_DS_EMPTY], dstat_q[`TBH_DS_FULL],
                        dstat_q, err_q, busy_o};
  wire [31:0] rsel =
      (addr_i == `TBH_A_CTRL) ? {28'h0000000, dev_rst_q, 1'b0, 2'(op_q)} :
      (addr_i == `TBH_A_CMD)  ? {24'h000000, cmd_q} :
      (addr_i == `TBH_A_LEN)  ? {18'h00000, rxbits_q, 2'h0, txbits_q} :
      (addr_i == `TBH_A_DISC) ? {30'h00000000, tdo_q, tms_q} :
      (addr_i == `TBH_A_TXD)  ? tx_q :
      (addr_i == `TBH_A_RXD)  ? rx_q :
      (addr_i == `TBH_A_STAT) ? stat_w : 32'h00000000;

  // ========================================================================
  // Device access selection per sequencer step
  logic [2:0] acc_addr;
  logic [7:0] acc_wd;
  logic       acc_rd;
  always_comb begin
    acc_addr = `TBH_DEV_CMD;
    acc_wd   = 8'h00;
    acc_rd   = 1'b0;
    case (seq_q)
      tbh_pkg::S_CMD:   acc_wd = cmd_q;
      tbh_pkg::S_SRST:  acc_wd = 8'h01 << `TBH_CMD_SRST;  // [RULE_03]
      tbh_pkg::S_TX: begin
        acc_addr = `TBH_DEV_OUT;
        acc_wd   = tx_byte;
      end
      tbh_pkg::S_RX: begin
        acc_addr = `TBH_DEV_IN;
        acc_rd   = 1'b1;
      end
      tbh_pkg::S_POLL: begin
        acc_addr = `TBH_DEV_STAT;
        acc_rd   = 1'b1;
      end
      tbh_pkg::S_DLO, tbh_pkg::S_DFALL: begin
        acc_addr = `TBH_DEV_DISC;
        acc_wd   = disc_byte(1'b0, tms_q, tdo_q);  // [RULE_17]
      end
      tbh_pkg::S_DHI: begin
        acc_addr = `TBH_DEV_DISC;
        acc_wd   = disc_byte(1'b1, tms_q, tdo_q);
      end
      tbh_pkg::S_DRD: begin
        acc_addr = `TBH_DEV_DISC;
        acc_rd   = 1'b1;
      end
      default: acc_rd = 1'b0;
    endcase
  end

  wire req      = (bus_q == tbh_pkg::B_IDLE) && (seq_q != tbh_pkg::S_IDLE);
  wire tmo      = (cnt_q == 9'(`TBH_RDY_TMO_CYC - 1));
  wire acc_done = ce_i && (bus_q == tbh_pkg::B_END) && (!rdy_s || tmo);
  wire acc_ok   = acc_done && !abort_q;
  wire abort_ev = ce_i && (bus_q == tbh_pkg::B_ACT) && !rdy_s && tmo;

  // ========================================================================
  // Bus engine: strobe held until ready, released early on timeout
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= tbh_pkg::B_IDLE; dev_strobe_n_o <= 1'b1; dev_d_oe_o <= 1'b0;
      dev_read_o <= 1'b1; dev_addr_o <= 3'h0; dev_d_o <= 8'h00;
      cnt_q <= 9'h000; rbyte_q <= 8'h00; abort_q <= 1'b0;
    end else if (ce_i) begin
      case (bus_q)
        tbh_pkg::B_IDLE: if (req) begin
          bus_q <= tbh_pkg::B_ACT; dev_strobe_n_o <= 1'b0; dev_addr_o <= acc_addr;
          dev_d_o <= acc_wd; dev_read_o <= acc_rd; dev_d_oe_o <= !acc_rd;
          cnt_q <= 9'h000; abort_q <= 1'b0;
        end
        tbh_pkg::B_ACT: if (rdy_s || tmo) begin
          bus_q <= tbh_pkg::B_END; dev_strobe_n_o <= 1'b1; cnt_q <= 9'h000;
          rbyte_q <= d_s; abort_q <= !rdy_s;  // [RULE_15]
        end else begin
          cnt_q <= cnt_q + 9'h001;
        end
        tbh_pkg::B_END: if (!rdy_s || tmo) begin
          bus_q <= tbh_pkg::B_IDLE; dev_d_oe_o <= 1'b0; dev_read_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 9'h001;
        end
        default: bus_q <= tbh_pkg::B_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Sequencer: a scan sends command first, then outgoing bytes, then incoming bytes
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      seq_q <= tbh_pkg::S_IDLE; idx_q <= 3'h0; rx_q <= 32'h00000000;
      dstat_q <= 8'h00; cmd_sent_q <= 1'b0;
    end else if (ce_i) begin
      if (go) begin
        seq_q <= first; idx_q <= 3'h0; cmd_sent_q <= 1'b0;
      end else if (acc_done && abort_q) begin
        seq_q <= tbh_pkg::S_IDLE;
      end else if (acc_ok) begin
        case (seq_q)
          tbh_pkg::S_CMD: begin
            cmd_sent_q <= 1'b1;  // [RULE_14]
            seq_q <= (tx_n != 3'h0) ? tbh_pkg::S_TX : after_tx;
          end
          tbh_pkg::S_TX: if (idx_up < tx_n) begin
            idx_q <= idx_up;  // [RULE_13]
          end else begin
            idx_q <= 3'h0; seq_q <= after_tx;
          end
          tbh_pkg::S_RX: begin
            rx_q[{idx_q[1:0], 3'h0} +: 8] <= rbyte_q;  // [RULE_19]
            idx_q <= idx_up;
            if (idx_up >= rx_n) seq_q <= tbh_pkg::S_IDLE;
          end
          tbh_pkg::S_POLL: begin
            dstat_q <= rbyte_q;  // [RULE_15] [RULE_19]
            seq_q <= tbh_pkg::S_IDLE;
          end
          tbh_pkg::S_DLO:   seq_q <= tbh_pkg::S_DHI;
          tbh_pkg::S_DHI:   seq_q <= tbh_pkg::S_DRD;
          tbh_pkg::S_DRD:   seq_q <= tbh_pkg::S_DFALL;
          default:          seq_q <= tbh_pkg::S_IDLE;
        endcase
      end
    end
  end

  // ========================================================================
  // Local registers written by software
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= tbh_pkg::OP_SCAN; dev_rst_q <= 1'b0; cmd_q <= 8'h00; txbits_q <= 6'h00;
      rxbits_q <= 6'h00; tms_q <= 1'b1; tdo_q <= 1'b1; tx_q <= 32'h00000000; err_q <= 1'b0;
    end else if (ce_i) begin
      if (w_ctrl) begin
        op_q <= new_op; dev_rst_q <= wdata_i[`TBH_CTRL_RST];
      end
      if (wr_i && addr_i == `TBH_A_CMD) cmd_q <= wdata_i[7:0];
      if (wr_i && addr_i == `TBH_A_LEN) begin
        txbits_q <= wdata_i[`TBH_LEN_TX +: `TBH_LEN_W];
        rxbits_q <= wdata_i[`TBH_LEN_RX +: `TBH_LEN_W];
      end
      if (wr_i && addr_i == `TBH_A_DISC) begin
        tms_q <= wdata_i[`TBH_DISC_TMS]; tdo_q <= wdata_i[`TBH_DISC_TDO];
      end
      if (wr_i && addr_i == `TBH_A_TXD) tx_q <= wdata_i;
      // A timeout while the strobe waits for ready sets the error, set wins over a same-cycle clear
      if (abort_ev) err_q <= 1'b1;
      else if (w_stat && wdata_i[`TBH_ST_ERR]) err_q <= 1'b0;
    end
  end

  // ========================================================================
  // TAP state mirror driven by discrete-mode TCK edges
  wire tck_rise = acc_ok && (seq_q == tbh_pkg::S_DHI);
  wire tck_fall = acc_ok && (seq_q == tbh_pkg::S_DFALL);
  wire to_reset = dev_rst_q || (acc_ok && seq_q == tbh_pkg::S_SRST);
  wire in_shift = (tap_q == tbh_pkg::TAP_SDR) || (tap_q == tbh_pkg::TAP_SIR);
  wire in_exit1 = (tap_q == tbh_pkg::TAP_E1DR) || (tap_q == tbh_pkg::TAP_E1IR);
  wire in_upd   = (tap_q == tbh_pkg::TAP_UDR) || (tap_q == tbh_pkg::TAP_UIR);
  wire in_cap   = (tap_q == tbh_pkg::TAP_CDR) || (tap_q == tbh_pkg::TAP_CIR);
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tap_q <= tbh_pkg::TAP_TLR; live_q <= 1'b0; tdi_q <= 1'b0;  // [RULE_22]
      cap_q <= 1'b0; upd_q <= 1'b0;
    end else if (ce_i) begin
      if (to_reset) begin
        tap_q <= tbh_pkg::TAP_TLR; live_q <= 1'b0;  // [RULE_03] [RULE_04]
      end else if (tck_rise) begin
        tap_q <= tap_next(tap_q, tms_q);  // [RULE_01] [RULE_02] [RULE_07] [RULE_11]
        if (in_cap) cap_q <= 1'b1;  // [RULE_05] [RULE_09]
      end else if (tck_fall) begin
        if (in_shift) live_q <= 1'b1;  // [RULE_06] [RULE_10]
        else if (in_exit1) live_q <= 1'b0;  // [RULE_07] [RULE_11]
        if (in_upd) upd_q <= 1'b1;  // [RULE_08] [RULE_12]
      end
      if (acc_ok && seq_q == tbh_pkg::S_DRD) tdi_q <= rbyte_q[`TBH_DC_TDI];
      if (go) begin
        cap_q <= 1'b0; upd_q <= 1'b0;
      end
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) rdata_q <= 32'h00000000;
    else if (ce_i) rdata_q <= rd_i ? rsel : 32'h00000000;
  end
  assign rdata_o     = rdata_q;
  assign busy_o      = (seq_q != tbh_pkg::S_IDLE);
  assign dev_rst_n_o = !dev_rst_q;  // [RULE_03]

  // ========================================================================
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  a_cmd_before_tx: assert property ((seq_q == tbh_pkg::S_TX) |-> cmd_sent_q)  // [RULE_14]
    else $error("outgoing byte before command");
  a_tx_first_byte: assert property (  // [RULE_13]
    (ce_i && req && seq_q == tbh_pkg::S_TX && idx_q == 3'h0 && txbits_q >= 6'h08)
    |=> (dev_d_o == $past(tx_q[7:0])) && !dev_strobe_n_o)
    else $error("first outgoing byte is not the low byte");
  a_abort_drop: assert property ((abort_ev) |=> dev_strobe_n_o && err_q ##1  // [RULE_15]
    (seq_q == tbh_pkg::S_IDLE || !ce_i))
    else $error("timed-out access not abandoned");
  a_strobe_hold: assert property (  // [RULE_15]
    (ce_i && bus_q == tbh_pkg::B_ACT && !rdy_s && !tmo) |=> !dev_strobe_n_o)
    else $error("strobe dropped before ready");
  a_tap_step: assert property ((tck_rise && !to_reset)  // [RULE_01]
    |=> tap_q == tap_next($past(tap_q), $past(tms_q)))
    else $error("TAP mirror did not follow TMS");
  a_soft_reset_tlr: assert property (  // [RULE_03]
    (acc_ok && seq_q == tbh_pkg::S_SRST) |=> tap_q == tbh_pkg::TAP_TLR && !live_q)
    else $error("soft reset left TAP outside reset");
  a_shift_live: assert property ((tck_fall && in_shift && !to_reset) |=> live_q)  // [RULE_06]
    else $error("TDO not live after shift fall");
  a_exit1_float: assert property ((tck_fall && in_exit1 && !to_reset) |=> !live_q)  // [RULE_07]
    else $error("TDO still live after exit fall");
  a_rx_low_byte: assert property (  // [RULE_19]
    (acc_ok && seq_q == tbh_pkg::S_RX && idx_q == 3'h0) |=> rx_q[7:0] == $past(rbyte_q))
    else $error("first incoming byte not placed low");
endmodule : tbh_host
`default_nettype wire

/* verilog/tbh_regs.svh */
// Offsets, field positions, device map and timing for the scan host controller
`ifndef TBH_REGS_SVH
`define TBH_REGS_SVH

// ==========================================================================
// Local register byte offsets
`define TBH_A_CTRL      5'h00
`define TBH_A_CMD       5'h04
`define TBH_A_LEN       5'h08
`define TBH_A_DISC      5'h0c
`define TBH_A_TXD       5'h10
`define TBH_A_RXD       5'h14
`define TBH_A_STAT      5'h18

// ==========================================================================
// Local field positions
`define TBH_CTRL_OP     0
`define TBH_CTRL_OP_W   2
`define TBH_CTRL_GO     2
`define TBH_CTRL_RST    3
`define TBH_LEN_TX      0
`define TBH_LEN_RX      8
`define TBH_LEN_W       6
`define TBH_DISC_TMS    0
`define TBH_DISC_TDO    1
`define TBH_ST_BUSY     0
`define TBH_ST_ERR      1
`define TBH_ST_DSTAT    2
`define TBH_ST_FULL     10
`define TBH_ST_EMPTY    11
`define TBH_ST_TDI      12
`define TBH_ST_TAP      13
`define TBH_ST_LIVE     17
`define TBH_ST_TLR      18
`define TBH_ST_CAP      19
`define TBH_ST_UPD      20

// ==========================================================================
// Device side map and bits
`define TBH_DEV_CMD     3'h0
`define TBH_DEV_STAT    3'h1
`define TBH_DEV_OUT     3'h2
`define TBH_DEV_IN      3'h3
`define TBH_DEV_DISC    3'h4
`define TBH_DS_FULL     6
`define TBH_DS_EMPTY    7
`define TBH_CMD_SRST    7
`define TBH_DC_TCK      0
`define TBH_DC_TMS      1
`define TBH_DC_TDO      2
`define TBH_DC_TRST     3
`define TBH_DC_TDI      4

// ==========================================================================
// Timing
`define TBH_CLK_NS      50
`define TBH_RDY_TMO_NS  12800
`define TBH_RDY_TMO_CYC (`TBH_RDY_TMO_NS / `TBH_CLK_NS)

`endif

/* verilog/tbh_pkg.sv */
// Types shared by the scan host controller
`default_nettype none
package tbh_pkg;
  typedef enum logic [3:0] {
    TAP_TLR, TAP_RTI, TAP_SDRS, TAP_CDR, TAP_SDR, TAP_E1DR, TAP_PDR, TAP_E2DR,
    TAP_UDR, TAP_SIRS, TAP_CIR, TAP_SIR, TAP_E1IR, TAP_PIR, TAP_E2IR, TAP_UIR
  } tbh_tap_e;
  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_TX, S_RX, S_SRST, S_POLL, S_DLO, S_DHI, S_DRD, S_DFALL
  } tbh_seq_e;
  typedef enum logic [1:0] {B_IDLE, B_ACT, B_END} tbh_bus_e;
  typedef enum logic [1:0] {OP_SCAN, OP_DISC, OP_SRST, OP_POLL} tbh_op_e;
endpackage : tbh_pkg
`default_nettype wire

/* verilog/tbh_sync.sv */
// Two flip-flop synchroniser, also used as reset release stage
`default_nettype none
module tbh_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         rstn_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else if (ce_i) begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : tbh_sync
`default_nettype wire

/* verif/tbh_dev_model.sv */
// Behavioural model of the scan master device on the host controller byte bus
`default_nettype none
module tbh_dev_model (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] d_i,
  input  wire logic       read_i,
  input  wire logic       strobe_n_i,
  input  wire logic [3:0] dly_i,
  input  wire logic       stall_i,
  output logic      [7:0] d_o,
  output logic            rdy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] oq[$];
  logic [7:0] iq[$];
  logic [7:0] sent[$];
  logic [7:0] disc;
  logic [3:0] cnt;
  logic       blk;

  // ==========================================================================
  // Register side effects of an accepted write
  task automatic do_write();
    if (addr_i == 3'h0 && d_i[7]) begin
      oq.delete();
      iq.delete();
      disc = 8'h0e;
    end else if (addr_i == 3'h0) begin
      oq.delete();
    end else if (addr_i == 3'h2) begin
      oq.push_back(d_i);
      sent.push_back(d_i);
      if (iq.size() < 4) iq.push_back(d_i);
    end else if (addr_i == 3'h4) begin
      disc = {3'h0, disc[4], d_i[3:0]};
    end
  endtask : do_write

  // Value returned by an accepted read
  function automatic logic [7:0] rd_val();
    case (addr_i)
      3'h1: return {iq.size() == 0, oq.size() == 4, 6'h00};
      3'h3: return iq.pop_front();
      3'h4: return disc;
      default: return 8'h00;
    endcase
  endfunction : rd_val

  // ==========================================================================
  // Ready handshake; a released bus shows a changing pattern
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oq.delete();
      iq.delete();
      disc = 8'h0e;  // TDO, TMS, TRST high
      cnt = 4'h0;
      rdy_o <= 1'b0;
      d_o <= 8'h5a;
    end else if (strobe_n_i) begin
      rdy_o <= 1'b0;
      cnt = 4'h0;
      d_o <= ~d_o;
    end else if (!rdy_o) begin
      blk = (!read_i && addr_i == 3'h2 && oq.size() == 4)
          || (read_i && addr_i == 3'h3 && iq.size() == 0);
      // Data is offered only once the programmed latency has run out
      if (cnt == dly_i && !blk && !stall_i) begin
        rdy_o <= 1'b1;
        if (read_i) d_o <= rd_val();
        else do_write();
      end else begin
        d_o <= ~d_o;
        if (cnt != dly_i) cnt = cnt + 4'h1;
      end
    end
  end
endmodule : tbh_dev_model
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the scan host controller against the device model
`default_nettype none
`include "tbh_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [4:0]  addr_i = 5'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [3:0]  dly = 4'h0;
  logic        stall = 1'b0;
  logic        ce = 1'b1;
  logic [31:0] got;
  wire  [31:0] rdata;
  wire  [2:0]  d_addr;
  wire  [7:0]  d_out;
  wire  [7:0]  d_in;
  wire  [7:0]  m_d;
  wire         d_oe, d_read, d_stb_n, d_rdy, d_rst_n, busy;
  int          n_errors = 0;
  int          n_compared = 0;

  // ==========================================================================
  // Clock, shared data bus and instances
  always #25 clock_i = ~clock_i;
  assign d_in = d_oe ? d_out : m_d;
  tbh_host u_tbh_host (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .dev_addr_o(d_addr),
    .dev_d_o(d_out), .dev_d_oe_o(d_oe), .dev_d_i(d_in), .dev_read_o(d_read),
    .dev_strobe_n_o(d_stb_n), .dev_rdy_i(d_rdy), .dev_rst_n_o(d_rst_n), .busy_o(busy));
  tbh_dev_model u_dev (.clock_i(clock_i), .rst_n_i(d_rst_n & rstn_i), .addr_i(d_addr),
    .d_i(d_in), .read_i(d_read), .strobe_n_i(d_stb_n), .dly_i(dly), .stall_i(stall),
    .d_o(m_d), .rdy_o(d_rdy));

  // ==========================================================================
  // Local bus cycles, completion wait and comparison
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 got = rdata;
  endtask : rd
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic go(input logic [1:0] op);
    wr(`TBH_A_CTRL, {29'h0, 1'b1, op});
    repeat (2) @(posedge clock_i);
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clock_i);
    chk({31'h0, busy}, 32'h0);
  endtask : go

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rd(`TBH_A_STAT);
    chk(got & 32'h0007e003, 32'h00040000);
    rd(5'h1c);
    chk(got, 32'h0);
    // A write while the clock enable is low must leave the register alone
    @(posedge clock_i);
    ce <= 1'b0;
    wr(`TBH_A_DISC, 32'h0);
    ce <= 1'b1;
    rd(`TBH_A_DISC);
    chk(got, 32'h3);
  endtask : t_reset
  task automatic t_poll();
    dly = 4'h3;
    go(2'h3);
    rd(`TBH_A_STAT);
    chk({22'h0, got[11:2]}, 32'h280);
  endtask : t_poll
  task automatic t_scan();
    dly = 4'h2;
    wr(`TBH_A_CMD, 32'h2a);
    wr(`TBH_A_LEN, 32'h0c0c);
    wr(`TBH_A_TXD, 32'h0000fcbc);
    go(2'h0);
    chk({u_dev.sent[1], u_dev.sent[0]}, 32'h0cbc);
    rd(`TBH_A_RXD);
    chk(got, 32'h00000cbc);
    u_dev.sent.delete();
    wr(`TBH_A_LEN, 32'h0020);
    wr(`TBH_A_TXD, 32'h89abcdef);
    go(2'h0);
    chk({u_dev.sent[3], u_dev.sent[2], u_dev.sent[1], u_dev.sent[0]}, 32'h89abcdef);
    go(2'h3);
    rd(`TBH_A_STAT);
    chk({30'h0, got[11:10]}, 32'h1);
  endtask : t_scan
  task automatic t_abort();
    stall = 1'b1;
    go(2'h3);
    stall = 1'b0;
    rd(`TBH_A_STAT);
    chk({30'h0, got[1:0]}, 32'h2);
    wr(`TBH_A_STAT, 32'h2);
    rd(`TBH_A_STAT);
    chk({31'h0, got[1]}, 32'h0);
  endtask : t_abort
  task automatic t_srst();
    go(2'h2);
    go(2'h3);
    rd(`TBH_A_STAT);
    chk({13'h0, got[18:13], 11'h0, got[11:10]}, 32'h00040002);
  endtask : t_srst
  task automatic t_disc();
    logic [11:0] tms;
    logic [7:0]  ex[12];
    tms = 12'b011111001100;
    // Update, capture, reset, live flags above the four-bit TAP state
    ex = '{8'h01, 8'h01, 8'h02, 8'h09, 8'h0a, 8'h5b, 8'h0c, 8'h8f, 8'h02, 8'h09, 8'h20,
           8'h01};
    for (int i = 0; i < 12; i++) begin
      wr(`TBH_A_DISC, {30'h0, 1'b1, tms[i]});
      go(2'h1);
      rd(`TBH_A_STAT);
      chk({24'h0, got[20:13]}, {24'h0, ex[i]});
    end
  endtask : t_disc
  task automatic t_devrst();
    wr(`TBH_A_DISC, 32'h2);
    go(2'h1);
    wr(`TBH_A_CTRL, 32'h8);
    repeat (2) @(posedge clock_i);
    chk({31'h0, d_rst_n}, 32'h0);
    wr(`TBH_A_CTRL, 32'h0);
    rd(`TBH_A_STAT);
    chk({13'h0, got[18:13], 13'h0}, 32'h00040000);
  endtask : t_devrst

  // ==========================================================================
  // Verdict, watchdog and main sequence
  task automatic close_out();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  initial begin
    #(50 * 60000);
    n_errors++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    t_reset();
    t_poll();
    t_scan();
    t_abort();
    t_disc();
    t_srst();
    t_devrst();
    close_out();
  end
endmodule : tb
`default_nettype wire
